// >>> src/sac_fifo.sv
`default_nettype none
module sac_fifo #(
    parameter int W = 8,       // Word width
    parameter int DEPTH = 16   // Number of words
) (
    input wire logic clk_i,          // Clock
    input wire logic rst_ni,         // Synchronised reset, active low
    input wire logic [W-1:0] in_data_i,  // Word to store
    input wire logic in_valid_i,     // Store request
    output logic in_ready_o,         // Room for a word
    output logic [W-1:0] out_data_o, // Oldest word
    output logic out_valid_o,        // A word is waiting
    input wire logic out_ready_i     // Drain side takes the word
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;  // Storage
        logic [AW-1:0] wp;             // Write index
        logic [AW-1:0] rp;             // Read index
        logic [AW:0] cnt;              // Words held
    } sac_fifo_s;
    sac_fifo_s q, d;
    logic push, pop;

    // Full and empty come from the count, so they never lie
    assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o = q.mem[q.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data_i;
            d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// >>> src/sac_pkg.sv
`default_nettype none
package sac_pkg;
    // Register indices on the control port
    localparam logic [7:0] SAC_REG_CLKDIR = 8'h09;  // Direction and polarity
    localparam logic [7:0] SAC_REG_DIVRST = 8'h0C;  // Divider run controls
    // Field positions in the direction/polarity register
    localparam int SAC_BIT_INVERT = 5;
    localparam int SAC_BIT_BOUT = 4;
    localparam int SAC_BIT_FOUT = 0;
    // Field positions in the divider run register
    localparam int SAC_BIT_BRUN = 1;
    localparam int SAC_BIT_FRUN = 0;
    // Reset values of the control bits
    localparam logic SAC_RST_INVERT = 1'b0;
    localparam logic SAC_RST_BOUT = 1'b0;
    localparam logic SAC_RST_FOUT = 1'b0;
    localparam logic SAC_RST_BRUN = 1'b0;
    localparam logic SAC_RST_FRUN = 1'b1;
    // Widths of the divider factors and of one captured word
    localparam int SAC_BDIV_W = 8;
    localparam int SAC_FDIV_W = 9;
    localparam int SAC_SAMPLE_W = 32;
    localparam int SAC_FIFO_DEPTH = 16;
    // One captured word and the frame half it came from
    typedef struct packed {
        logic right;                    // Frame clock level during the word
        logic [SAC_SAMPLE_W-1:0] data;  // Bits in arrival order, last in LSB
    } sac_sample_s;
    localparam int SAC_WORD_W = SAC_SAMPLE_W + 1;
endpackage
`default_nettype wire

// >>> src/sac_top.sv
// How it works
// - Normal polarity: transitions on bit clock falling
// - Inverted polarity: transitions on bit clock rising
// - Bit clock pin driven only when enabled
// - Frame clock pin driven only when enabled
// - Bit clock is master clock divided
// - Frame clock is bit clock divided
// - Bit divider held until run set
// - Frame divider runs unless run cleared
`default_nettype none
module sac_top (
    input wire logic mclk_i,                               // Master clock, 250 MHz
    input wire logic rstn_i,                               // Async reset, active low
    input wire logic [7:0] reg_addr_i,                     // Register index
    input wire logic [7:0] reg_wdata_i,                    // Write data
    input wire logic reg_wr_i,                             // Write strobe
    input wire logic reg_rd_i,                             // Read strobe
    output logic [7:0] reg_rdata_o,                        // Read data, a cycle after strobe
    input wire logic [sac_pkg::SAC_BDIV_W-1:0] bdiv_i,     // Master clocks per bit clock
    input wire logic [sac_pkg::SAC_FDIV_W-1:0] fdiv_i,     // Bit clocks per frame
    input wire logic bitclk_i,                             // Bit clock pin in
    output logic bitclk_o,                                 // Bit clock pin out
    output logic bitclk_oe_o,                              // Bit clock drive enable
    input wire logic frameclk_i,                           // Frame clock pin in
    output logic frameclk_o,                               // Frame clock pin out
    output logic frameclk_oe_o,                            // Frame clock drive enable
    input wire logic sdin_i,                               // Serial data pin
    output sac_pkg::sac_sample_s sample_o,                 // Oldest captured word
    output logic sample_valid_o,                           // Word waiting
    input wire logic sample_ready_i,                       // Consumer takes word
    output logic overrun_o                                 // Word lost, sticky until reset
);
    import sac_pkg::*;

    typedef struct packed {
        logic [2:0] bsync;               // Bit clock pin: two sync stages and history
        logic [2:0] fsync;               // Frame clock pin: same
        logic [1:0] dsync;               // Data pin sync stages
        logic invert;                    // bitclk_invert
        logic bout;                      // bitclk_out_en
        logic fout;                      // frameclk_out_en
        logic brun;                      // bitclk_div_run
        logic frun;                      // frameclk_div_run
        logic [SAC_BDIV_W-1:0] bcnt;     // Master clock count in half period
        logic bgen;                      // Generated bit clock, uninverted
        logic [SAC_FDIV_W-1:0] fcnt;     // Bit clock count in half frame
        logic fgen;                      // Generated frame clock
        logic lastf;                     // Frame level at last sample
        logic [SAC_SAMPLE_W-1:0] shreg;  // Word being assembled
        logic pend_v;                    // Finished word waiting for the FIFO
        sac_sample_s pend;               // That word
        logic overrun;                   // A word was dropped
        logic [7:0] rdata;               // Read data register
    } sac_state_s;

    sac_state_s q, d;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [SAC_BDIV_W-1:0] bhalf;
    logic [SAC_FDIV_W-1:0] fhalf;
    logic btog, bfall, brise, samp, flev;
    logic fifo_ready;
    logic [SAC_WORD_W-1:0] fifo_out;

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Half periods; odd factors round down, so keep factors even
    assign bhalf = bdiv_i >> 1;
    assign fhalf = fdiv_i >> 1;
    // Divider toggles the bit clock when the half period ends
    assign btog = q.brun && (q.bcnt >= bhalf - 1'b1);
    assign bfall = btog && q.bgen;                          // Transition edge enable
    assign brise = btog && !q.bgen;                         // Sample edge enable
    // Sample on the edge opposite to the transitions
    always_comb begin
        if (q.bout) begin
            samp = brise;
        end else if (q.invert) begin
            samp = !q.bsync[1] && q.bsync[2];
        end else begin
            samp = q.bsync[1] && !q.bsync[2];
        end
        flev = q.fout ? q.fgen : q.fsync[1];
    end

    // Next state of the whole block
    always_comb begin
        d = q;
        d.bsync = {q.bsync[1:0], bitclk_i};
        d.fsync = {q.fsync[1:0], frameclk_i};
        d.dsync = {q.dsync[0], sdin_i};
        // Register writes
        if (reg_wr_i && reg_addr_i == SAC_REG_CLKDIR) begin
            d.invert = reg_wdata_i[SAC_BIT_INVERT];
            d.bout = reg_wdata_i[SAC_BIT_BOUT];
            d.fout = reg_wdata_i[SAC_BIT_FOUT];
        end
        if (reg_wr_i && reg_addr_i == SAC_REG_DIVRST) begin
            d.brun = reg_wdata_i[SAC_BIT_BRUN];
            d.frun = reg_wdata_i[SAC_BIT_FRUN];
        end
        // Register reads; reserved bits and unmapped indices read zero
        if (reg_rd_i) begin
            d.rdata = 8'h00;
            if (reg_addr_i == SAC_REG_CLKDIR) begin
                d.rdata[SAC_BIT_INVERT] = q.invert;
                d.rdata[SAC_BIT_BOUT] = q.bout;
                d.rdata[SAC_BIT_FOUT] = q.fout;
            end else if (reg_addr_i == SAC_REG_DIVRST) begin
                d.rdata[SAC_BIT_BRUN] = q.brun;
                d.rdata[SAC_BIT_FRUN] = q.frun;
            end
        end
        // Bit clock divider
        if (!q.brun) begin
            d.bcnt = '0;
            d.bgen = 1'b0;
        end else if (btog) begin
            d.bcnt = '0;
            d.bgen = !q.bgen;
        end else begin
            d.bcnt = q.bcnt + 1'b1;
        end
        // Frame clock divider, stepped on bit clock transition edges
        if (!q.frun) begin
            d.fcnt = '0;
            d.fgen = 1'b0;
        end else if (bfall) begin
            if (q.fcnt >= fhalf - 1'b1) begin
                d.fcnt = '0;
                d.fgen = !q.fgen;
            end else begin
                d.fcnt = q.fcnt + 1'b1;
            end
        end
        // Hand the pending word to the FIFO when it has room
        if (q.pend_v && fifo_ready) begin
            d.pend_v = 1'b0;
        end
        // Capture; a frame level change closes the word
        if (samp) begin
            d.lastf = flev;
            if (flev != q.lastf) begin
                d.shreg = {{(SAC_SAMPLE_W-1){1'b0}}, q.dsync[1]};
                if (d.pend_v) begin
                    d.overrun = 1'b1;                         // Stalled FIFO, word lost
                end else begin
                    d.pend_v = 1'b1;
                    d.pend.right = q.lastf;
                    d.pend.data = q.shreg;
                end
            end else begin
                d.shreg = {q.shreg[SAC_SAMPLE_W-2:0], q.dsync[1]};
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.invert <= SAC_RST_INVERT;
            q.bout <= SAC_RST_BOUT;
            q.fout <= SAC_RST_FOUT;
            q.brun <= SAC_RST_BRUN;
            q.frun <= SAC_RST_FRUN;
        end else begin
            q <= d;
        end
    end

    // Pins: inverted mode moves transitions to the pin's rising edge
    assign bitclk_o = q.bgen ^ q.invert;
    assign bitclk_oe_o = q.bout;
    assign frameclk_o = q.fgen;
    assign frameclk_oe_o = q.fout;
    assign reg_rdata_o = q.rdata;
    assign overrun_o = q.overrun;
    assign sample_o = sac_sample_s'(fifo_out);

    // Word buffer; a slow consumer stalls the pending word
    sac_fifo #(
        .W(SAC_WORD_W),
        .DEPTH(SAC_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .rst_ni(rst_n),
        .in_data_i(q.pend),
        .in_valid_i(q.pend_v),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_out),
        .out_valid_o(sample_valid_o),
        .out_ready_i(sample_ready_i)
    );

    sequence s_wr_dir;
        reg_wr_i && reg_addr_i == SAC_REG_CLKDIR;
    endsequence
    sequence s_wr_div;
        reg_wr_i && reg_addr_i == SAC_REG_DIVRST;
    endsequence

    property p_slave_norm;
        // Tie the sample strobe to the pin itself, so a slip in the sync stages shows up
        @(posedge mclk_i) disable iff (!rst_n) (!q.bout && !q.invert && samp)
            |-> ($past(bitclk_i, 2) && !$past(bitclk_i, 3));
    endproperty
    a_slave_norm: assert property (p_slave_norm) else $error("normal sample not on rising pin edge");
    property p_slave_inv;
        @(posedge mclk_i) disable iff (!rst_n) (!q.bout && q.invert && samp)
            |-> (!$past(bitclk_i, 2) && $past(bitclk_i, 3));
    endproperty
    a_slave_inv: assert property (p_slave_inv) else $error("inverted sample not on falling pin edge");
    property p_bout;
        @(posedge mclk_i) disable iff (!rst_n) s_wr_dir |=> bitclk_oe_o == $past(reg_wdata_i[SAC_BIT_BOUT]);
    endproperty
    a_bout: assert property (p_bout) else $error("bit clock enable not written");
    property p_fout;
        @(posedge mclk_i) disable iff (!rst_n) s_wr_dir |=> frameclk_oe_o == $past(reg_wdata_i[SAC_BIT_FOUT]);
    endproperty
    a_fout: assert property (p_fout) else $error("frame clock enable not written");
    property p_bdiv;
        @(posedge mclk_i) disable iff (!rst_n) ($changed(q.bgen) && $past(q.brun)) |-> $past(q.bcnt) == $past(bhalf) - 1'b1;
    endproperty
    a_bdiv: assert property (p_bdiv) else $error("bit clock toggled off count");
    property p_fdiv;
        @(posedge mclk_i) disable iff (!rst_n) ($changed(q.fgen) && $past(q.frun)) |-> $past(bfall);
    endproperty
    a_fdiv: assert property (p_fdiv) else $error("frame clock toggled off a bit clock edge");
    property p_bhold;
        // The cycle after the write still steps the old divider, so look one cycle later
        @(posedge mclk_i) disable iff (!rst_n) (s_wr_div ##1 !q.brun) |=> (!q.bgen && q.bcnt == '0) [*2];
    endproperty
    a_bhold: assert property (p_bhold) else $error("held bit divider not static");
    property p_fhold;
        @(posedge mclk_i) disable iff (!rst_n) !q.frun |=> (!q.fgen && q.fcnt == '0);
    endproperty
    a_fhold: assert property (p_fhold) else $error("held frame divider not static");
endmodule
`default_nettype wire

// >>> test/sac_src_model.sv
`default_nettype none
module sac_src_model (
    input wire logic en_i,        // Traffic on
    input wire logic master_i,    // Follow the device clocks
    input wire logic invert_i,    // Launch on rising bit clock
    input wire logic ext_bclk_i,  // Bit clock wire
    input wire logic ext_fclk_i,  // Frame clock wire
    output logic bclk_o,          // Own bit clock
    output logic fclk_o,          // Own frame clock
    output logic sdin_o           // Serial data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [32:0] exp_q[$];      // Words the device should deliver
    event word_ev;              // A full word was noted
    logic [31:0] word = 32'h0;  // Word being sent
    logic lvl = 1'b0;           // Frame level of that word
    int cnt = 0;                // Bits sent of it
    wire logic lb = (master_i ? ext_bclk_i : bclk_o) ^ invert_i;  // Falls at launch
    initial begin
        bclk_o = 1'b0;
        fclk_o = 1'b0;
        sdin_o = 1'b0;
    end
    // Own clock stands still outside traffic; idle data wiggles so no stale bit looks valid
    always #20 begin
        bclk_o = (en_i && !master_i) ? ~bclk_o : 1'b0;
        if (!en_i) sdin_o = ~sdin_o;
    end
    // Launch one bit; a frame change starts a new word, MSB first
    always @(negedge lb) if (en_i) begin
        if (!master_i && cnt == 32) fclk_o = ~fclk_o;
        #6;
        // Device frame flop may trail its bit clock, so look a little later
        if ((master_i ? ext_fclk_i : fclk_o) !== lvl) begin
            if (cnt == 32) begin
                exp_q.push_back({lvl, word});
                ->word_ev;
            end
            lvl = ~lvl;
            cnt = 0;
            word = $urandom;
        end
        sdin_o = (cnt < 32) ? word[31 - cnt] : ~sdin_o;
        cnt++;
    end
endmodule
`default_nettype wire

// >>> test/sac_top_tb.sv
`default_nettype none
module sac_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sac_pkg::*;
    logic mclk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;  // Clock, reset, strobes
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;     // Register port
    logic [SAC_BDIV_W-1:0] bdiv_i = 8'h04;  // Bit clock factor
    logic [SAC_FDIV_W-1:0] fdiv_i = 9'h008; // Frame factor
    logic bitclk_o, bitclk_oe_o, frameclk_o, frameclk_oe_o, sample_valid_o, overrun_o;  // Outputs
    logic sample_ready_i = 1'b0, stall = 1'b1, chk_on = 1'b0;  // Consumer side
    logic src_en = 1'b0, src_master = 1'b0, src_inv = 1'b0, src_b, src_f, src_d;  // Source
    sac_sample_s sample_o;  // Oldest word
    int err_total = 0, checks_done = 0, cyc = 0, bd;  // Counters
    // Pin level: whoever has its enable up drives the wire
    wire logic bclk_w = bitclk_oe_o ? bitclk_o : src_b;
    wire logic fclk_w = frameclk_oe_o ? frameclk_o : src_f;
    sac_top sac_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .bdiv_i(bdiv_i), .fdiv_i(fdiv_i), .bitclk_i(bclk_w), .bitclk_o(bitclk_o),
        .bitclk_oe_o(bitclk_oe_o), .frameclk_i(fclk_w), .frameclk_o(frameclk_o),
        .frameclk_oe_o(frameclk_oe_o), .sdin_i(src_d), .sample_o(sample_o),
        .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i), .overrun_o(overrun_o));
    sac_src_model src_inst (.en_i(src_en), .master_i(src_master), .invert_i(src_inv),
        .ext_bclk_i(bclk_w), .ext_fclk_i(fclk_w), .bclk_o(src_b), .fclk_o(src_f), .sdin_o(src_d));
    initial forever #2 mclk_i = ~mclk_i;
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_total++;
            results();
        end
    end
    logic take;  // Consumer takes the standing word at the next rising edge
    // Consumer takes words at random unless stalled on purpose; a word that stands
    // while ready goes up is compared here, where it is settled, before it is taken
    always @(negedge mclk_i) begin
        take = stall ? 1'b0 : 1'($urandom);
        sample_ready_i <= take;
        if (chk_on && take && sample_valid_o === 1'b1) begin
            if (src_inst.exp_q.size() == 0) check("extra word", 33'h1, 33'h0);
            else check("word", sample_o, src_inst.exp_q.pop_front());
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
        check("register", 33'(reg_rdata_o), 33'(e));
    endtask
    function automatic logic pin(input logic fr);
        return fr ? frameclk_o : bitclk_o;
    endfunction
    // Cycles between two toggles of a generated clock, bounded
    task automatic half(input logic fr, input int exp);
        logic v;
        int n;
        for (int k = 0; k < 2; k++) begin
            v = pin(fr);
            n = 0;
            while (pin(fr) === v && n < 3000) begin
                @(negedge mclk_i);
                n++;
            end
        end
        check(fr ? "frame half period" : "bit half period", 33'(n), 33'(exp));
    endtask
    // A held divider output must not move
    task automatic still(input logic fr, input logic e);
        logic ok;
        ok = 1'b1;
        repeat (4) @(negedge mclk_i);
        repeat (64) begin
            @(negedge mclk_i);
            ok &= (pin(fr) === e);
        end
        check(fr ? "frame held" : "bit held", 33'(ok), 33'h1);
    endtask
    // Warm up past partial words, then check a run of whole ones
    task automatic capture(input logic m, input logic inv, input int words);
        src_master = m;
        src_inv = inv;
        src_en = 1'b1;
        stall = 1'b0;
        repeat (3) @(src_inst.word_ev);
        repeat (30) @(negedge mclk_i);
        src_inst.exp_q.delete();
        chk_on = 1'b1;
        repeat (words) @(src_inst.word_ev);
        repeat (60) @(negedge mclk_i);
        check("words left", 33'(src_inst.exp_q.size()), 33'h0);
        chk_on = 1'b0;
        src_en = 1'b0;
        $display("Test capture master=%0d invert=%0d done", m, inv);
    endtask
    initial begin
        void'($urandom(65645));
        repeat (5) @(negedge mclk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rd(SAC_REG_CLKDIR, 8'h00);
        rd(SAC_REG_DIVRST, 8'h01);
        check("pin enables", 33'({bitclk_oe_o, frameclk_oe_o}), 33'h0);
        wr(SAC_REG_CLKDIR, 8'hFF);
        rd(SAC_REG_CLKDIR, 8'h31);
        check("pin enables", 33'({bitclk_oe_o, frameclk_oe_o}), 33'h3);
        wr(8'h0A, 8'hFF);
        rd(8'h0A, 8'h00);
        wr(SAC_REG_DIVRST, 8'hFE);
        rd(SAC_REG_DIVRST, 8'h02);
        still(1'b1, 1'b0);
        wr(SAC_REG_DIVRST, 8'h00);
        still(1'b0, 1'b1);
        wr(SAC_REG_CLKDIR, 8'h11);
        still(1'b0, 1'b0);
        $display("Test registers and held dividers done");
        // Dividers restarted with a fresh random bit clock factor, programmed while held
        repeat (3) begin
            wr(SAC_REG_DIVRST, 8'h00);
            bd = 2 * (1 + ($urandom % 8));
            bdiv_i = 8'(bd);
            wr(SAC_REG_DIVRST, 8'h03);
            half(1'b0, bd / 2);
            half(1'b1, bd * 4);
        end
        wr(SAC_REG_DIVRST, 8'h02);
        still(1'b1, 1'b0);
        $display("Test dividers done");
        wr(SAC_REG_CLKDIR, 8'h00);
        capture(1'b0, 1'b0, 4);
        wr(SAC_REG_CLKDIR, 8'h20);
        capture(1'b0, 1'b1, 4);
        wr(SAC_REG_DIVRST, 8'h00);
        bdiv_i = 8'h10;
        fdiv_i = 9'h040;
        wr(SAC_REG_CLKDIR, 8'h11);
        wr(SAC_REG_DIVRST, 8'h03);
        capture(1'b1, 1'b0, 3);
        // Master with inverted polarity: pin transitions move to its rising edge
        wr(SAC_REG_CLKDIR, 8'h31);
        capture(1'b1, 1'b1, 3);
        // Stalled consumer: FIFO fills, then a word is lost
        wr(SAC_REG_CLKDIR, 8'h00);
        stall = 1'b1;
        check("no overrun yet", 33'(overrun_o), 33'h0);
        src_master = 1'b0;
        src_en = 1'b1;
        repeat (20) @(src_inst.word_ev);
        repeat (40) @(negedge mclk_i);
        src_en = 1'b0;
        check("full valid", 33'(sample_valid_o), 33'h1);
        check("overrun", 33'(overrun_o), 33'h1);
        stall = 1'b0;
        repeat (200) @(negedge mclk_i);
        check("drained", 33'(sample_valid_o), 33'h0);
        $display("Test overrun done");
        results();
    end
endmodule
`default_nettype wire
